// >>> rtl/lcd_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the
// segment LCD controller. Definitions only, shared by the package and lcd_ctrl.
`ifndef LCD_CTRL_CFG_SVH
`define LCD_CTRL_CFG_SVH

// Register byte offsets on the AHB-Lite port
`define LCD_OFS_CTRL1 12'h000
`define LCD_OFS_CTRL2 12'h004
`define LCD_OFS_CTRL3 12'h008
`define LCD_OFS_COMEN 12'h00C
`define LCD_OFS_SEGEN1 12'h010
`define LCD_OFS_SEGEN2 12'h014
`define LCD_OFS_STATUS 12'h018
`define LCD_RAM_BASE 12'h100
`define LCD_RAM_WORDS 4'hB

// panel_control_one fields
`define LCD_F_MODE_LSB 0
`define LCD_F_DRIVE_DIVIDER_SELECT 3
`define LCD_F_BIAS4 4
`define LCD_F_CLKSEL 5
`define LCD_F_DIV_LSB 8

// frame event fields, panel_control_three fields
`define LCD_F_FLAG 0
`define LCD_F_IEN 1
`define LCD_F_PORT_INPUT_CONTROL 5

// display_mode_select encodings
`define LCD_MODE_STOP 3'h0
`define LCD_MODE_4COM_HALF 3'h1
`define LCD_MODE_4COM_THIRD 3'h2
`define LCD_MODE_4COM_QUARTER 3'h3
`define LCD_MODE_8COM 3'h4

// Drive level codes, index of the drive-level pin selected
`define LCD_LVL_GND 3'h0
`define LCD_LVL_LOW 3'h1
`define LCD_LVL_MID 3'h2
`define LCD_LVL_TOP 3'h4

// Reset values and timing counts
`define LCD_RST_DIV 8'h00
`define LCD_COM_SLOT_TICKS 8'h04
`define LCD_COMS_MAX 8
`define LCD_SEGS_MAX 44
`define LCD_SEGS_8COM 40

`endif

// >>> rtl/lcd_ctrl_pkg.sv
// Types and the drive level function of the segment LCD controller.
// Relies on lcd_ctrl_cfg.svh for every numeric constant.
`include "lcd_ctrl_cfg.svh"

package lcd_ctrl_pkg;

    typedef logic [2:0] drive_level_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ODD,
        ST_EVEN
    } frame_state_t;

    // Odd frame level; even frame mirrors it about the mid level
    function automatic drive_level_t drive_level(input logic is_com,
            input logic active, input logic half_bias, input logic even);
        drive_level_t lvl;
        if (is_com) begin
            lvl = active ? `LCD_LVL_TOP :
                  (half_bias ? `LCD_LVL_MID : `LCD_LVL_LOW);
        end else begin
            lvl = active ? `LCD_LVL_GND :
                  (half_bias ? `LCD_LVL_TOP : `LCD_LVL_MID);
        end
        if (even) begin
            lvl = `LCD_LVL_TOP - lvl;
        end
        return lvl;
    endfunction

endpackage

// >>> rtl/lcd_clk_prescaler.sv
// Clock selector and prescaler producing the LCDC clock tick.
// Assumes sub_clk_tick is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/1ps

module lcd_clk_prescaler #(
    parameter int DIV_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic clk_sel,
    input wire logic sub_clk_tick,
    input wire logic [DIV_W-1:0] divide,
    output logic lcdc_tick
);
    logic [DIV_W-1:0] cnt_q;
    logic src_pulse;

    // Peripheral clock counts every edge, sub-clock only on its pulse
    assign src_pulse = clk_sel ? 1'b1 : sub_clk_tick;
    assign lcdc_tick = enable && src_pulse && (cnt_q == divide);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!enable || lcdc_tick) begin
            cnt_q <= '0;
        end else if (src_pulse) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// >>> rtl/lcd_display_memory.sv
// Display memory with word access and per-segment bit extraction.
// Assumes word writes only; read and segment paths are combinational.
`timescale 1ns/1ps

module lcd_display_memory #(
    parameter int WORDS = 11,
    parameter int SEGS = 44,
    parameter int SEGS_8COM = 40
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [3:0] word_idx,
    input wire logic [31:0] wr_data,
    output logic [31:0] rd_data,
    input wire logic four_com,
    input wire logic [2:0] com_idx,
    output logic [SEGS-1:0] seg_bits
);
    logic [7:0] mem_q [WORDS*4];

    assign rd_data = {mem_q[word_idx*4+3], mem_q[word_idx*4+2],
                      mem_q[word_idx*4+1], mem_q[word_idx*4]};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < WORDS*4; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_en) begin
            for (int b = 0; b < 4; b++) begin
                mem_q[word_idx*4+b] <= wr_data[b*8 +: 8];
            end
        end
    end

    // Live memory feeds the segments, so a write shows without delay
    for (genvar s = 0; s < SEGS; s++) begin : g_seg
        always_comb begin
            if (four_com) begin
                seg_bits[s] = mem_q[s/2][(s%2)*4 + com_idx[1:0]];
            end else if (s < SEGS_8COM) begin
                seg_bits[s] = mem_q[s][com_idx];
            end else begin
                seg_bits[s] = 1'b0;
            end
        end
    end
endmodule

// >>> rtl/lcd_ctrl.sv
// Segment LCD drive controller: AHB-Lite registers, display memory,
// timing generator and two-frame AC waveform on common and segment pins.
// Assumes a single AHB-Lite master, word transfers, sys_clk at 250 MHz.
`timescale 1ns/1ps
`include "lcd_ctrl_cfg.svh"

module lcd_ctrl #(
    parameter int DIV_W = 8,
    parameter int NCOM = `LCD_COMS_MAX,
    parameter int NSEG = `LCD_SEGS_MAX
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic sub_clk_tick,
    output lcd_ctrl_pkg::drive_level_t common_outputs [NCOM],
    output lcd_ctrl_pkg::drive_level_t segment_outputs [NSEG],
    output logic [NCOM-1:0] common_pin_enable,
    output logic [NSEG-1:0] segment_pin_enable,
    output logic [4:0] drive_level_pin_enable,
    output logic port_input_control,
    output logic divider_connect,
    output logic drive_cutoff_switch,
    output logic frame_irq
);
    import lcd_ctrl_pkg::*;

    // Control registers
    logic [2:0] mode_q;
    logic drive_divider_select_q;
    logic bias4_q;
    logic clksel_q;
    logic [DIV_W-1:0] div_q;
    logic flag_q;
    logic ien_q;
    logic [4:0] vpin_q;
    logic port_input_control_q;
    logic [NCOM-1:0] comen_q;
    logic [NSEG-1:0] segen_q;

    // Bus data phase
    logic dph_q;
    logic dwr_q;
    logic [11:0] daddr_q;
    logic rd_wait_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata_d;
    logic addr_take;
    logic wr_go;
    logic ram_hit;
    logic [31:0] ram_rd;

    // Timing generator
    frame_state_t state_q;
    logic [2:0] com_idx_q;
    logic [7:0] slot_q;
    logic [2:0] last_com;
    logic lcdc_tick;
    logic slot_end;
    logic cycle_done;
    logic four_com;
    logic half_bias;
    logic running;
    logic [NSEG-1:0] seg_bits;
    drive_level_t com_lvl_q [NCOM];
    drive_level_t seg_lvl_q [NSEG];
    drive_level_t com_lvl_d [NCOM];
    drive_level_t seg_lvl_d [NSEG];

    // AHB-Lite slave: writes complete at once, reads take one wait state
    assign addr_take = hsel && hready && htrans[1];
    assign wr_go = dph_q && dwr_q;
    assign ram_hit = (daddr_q[11:8] == 4'(`LCD_RAM_BASE >> 8))
                     && (daddr_q[7:2] < {2'h0, `LCD_RAM_WORDS});
    assign hreadyout = !rd_wait_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            daddr_q <= 12'h000;
        end else if (hreadyout) begin
            dph_q <= addr_take;
            dwr_q <= hwrite;
            daddr_q <= haddr[11:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            rd_wait_q <= hreadyout && addr_take && !hwrite;
            if (rd_wait_q) begin
                hrdata_q <= rdata_d;
            end
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (daddr_q)
            `LCD_OFS_CTRL1: begin
                rdata_d[`LCD_F_MODE_LSB +: 3] = mode_q;
                rdata_d[`LCD_F_DRIVE_DIVIDER_SELECT] = drive_divider_select_q;
                rdata_d[`LCD_F_BIAS4] = bias4_q;
                rdata_d[`LCD_F_CLKSEL] = clksel_q;
                rdata_d[`LCD_F_DIV_LSB +: DIV_W] = div_q;
            end
            `LCD_OFS_CTRL2: begin
                rdata_d[`LCD_F_FLAG] = flag_q;
                rdata_d[`LCD_F_IEN] = ien_q;
            end
            `LCD_OFS_CTRL3: begin
                rdata_d[4:0] = vpin_q;
                rdata_d[`LCD_F_PORT_INPUT_CONTROL] = port_input_control_q;
            end
            `LCD_OFS_COMEN: rdata_d[NCOM-1:0] = comen_q;
            `LCD_OFS_SEGEN1: rdata_d = segen_q[31:0];
            `LCD_OFS_SEGEN2: rdata_d[NSEG-33:0] = segen_q[NSEG-1:32];
            `LCD_OFS_STATUS: begin
                rdata_d[2:0] = com_idx_q;
                rdata_d[3] = (state_q == ST_EVEN);
                rdata_d[4] = running;
            end
            default: begin
                if (ram_hit) begin
                    rdata_d = ram_rd;
                end
            end
        endcase
    end

    // Control register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `LCD_MODE_STOP;
            drive_divider_select_q <= 1'b0;
            bias4_q <= 1'b0;
            clksel_q <= 1'b0;
            div_q <= `LCD_RST_DIV;
        end else if (wr_go && daddr_q == `LCD_OFS_CTRL1) begin
            mode_q <= hwdata[`LCD_F_MODE_LSB +: 3];
            drive_divider_select_q <= hwdata[`LCD_F_DRIVE_DIVIDER_SELECT];
            bias4_q <= hwdata[`LCD_F_BIAS4];
            clksel_q <= hwdata[`LCD_F_CLKSEL];
            div_q <= hwdata[`LCD_F_DIV_LSB +: DIV_W];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vpin_q <= 5'h00;
            port_input_control_q <= 1'b0;
            comen_q <= '0;
            segen_q <= '0;
        end else if (wr_go) begin
            case (daddr_q)
                `LCD_OFS_CTRL3: begin
                    vpin_q <= hwdata[4:0];
                    port_input_control_q <= hwdata[`LCD_F_PORT_INPUT_CONTROL];
                end
                `LCD_OFS_COMEN: comen_q <= hwdata[NCOM-1:0];
                `LCD_OFS_SEGEN1: segen_q[31:0] <= hwdata;
                `LCD_OFS_SEGEN2: segen_q[NSEG-1:32] <= hwdata[NSEG-33:0];
                default: begin
                end
            endcase
        end
    end

    // Frame event: hardware set wins over a software clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            ien_q <= 1'b0;
        end else begin
            if (cycle_done) begin
                flag_q <= 1'b1;
            end else if (wr_go && daddr_q == `LCD_OFS_CTRL2
                         && !hwdata[`LCD_F_FLAG]) begin
                flag_q <= 1'b0;
            end
            if (wr_go && daddr_q == `LCD_OFS_CTRL2) begin
                ien_q <= hwdata[`LCD_F_IEN];
            end
        end
    end

    assign frame_irq = flag_q && ien_q;
    assign divider_connect = drive_divider_select_q;
    assign drive_cutoff_switch = (mode_q != `LCD_MODE_STOP);
    assign common_pin_enable = comen_q;
    assign segment_pin_enable = segen_q;
    assign drive_level_pin_enable = vpin_q;
    assign port_input_control = port_input_control_q;

    lcd_display_memory #(
        .WORDS(11),
        .SEGS(NSEG),
        .SEGS_8COM(`LCD_SEGS_8COM)
    ) u_mem (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(wr_go && ram_hit),
        .word_idx(daddr_q[5:2]),
        .wr_data(hwdata),
        .rd_data(ram_rd),
        .four_com(four_com),
        .com_idx(com_idx_q),
        .seg_bits(seg_bits)
    );

    lcd_clk_prescaler #(
        .DIV_W(DIV_W)
    ) u_presc (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(running),
        .clk_sel(clksel_q),
        .sub_clk_tick(sub_clk_tick),
        .divide(div_q),
        .lcdc_tick(lcdc_tick)
    );

    // Duty from mode; half bias only exists in 4-common half duty
    always_comb begin
        case (mode_q)
            `LCD_MODE_4COM_HALF: last_com = 3'h1;
            `LCD_MODE_4COM_THIRD: last_com = 3'h2;
            `LCD_MODE_4COM_QUARTER: last_com = 3'h3;
            `LCD_MODE_8COM: last_com = 3'h7;
            default: last_com = 3'h0;
        endcase
    end

    assign four_com = (mode_q != `LCD_MODE_8COM);
    assign half_bias = (mode_q == `LCD_MODE_4COM_HALF);
    assign running = (mode_q != `LCD_MODE_STOP) && (mode_q <= `LCD_MODE_8COM);
    assign slot_end = lcdc_tick && (slot_q == `LCD_COM_SLOT_TICKS - 8'h01);
    assign cycle_done = slot_end && (state_q == ST_EVEN)
                        && (com_idx_q == last_com);

    // Timing generator: common slots within odd then even frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            com_idx_q <= 3'h0;
            slot_q <= 8'h00;
        end else if (!running) begin
            state_q <= ST_IDLE;
            com_idx_q <= 3'h0;
            slot_q <= 8'h00;
        end else begin
            // Idle ticks must not shorten the first common slot
            if (lcdc_tick && state_q != ST_IDLE) begin
                slot_q <= slot_end ? 8'h00 : slot_q + 8'h01;
            end
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_ODD;
                    com_idx_q <= 3'h0;
                end
                ST_ODD: begin
                    if (slot_end) begin
                        if (com_idx_q >= last_com) begin
                            state_q <= ST_EVEN;
                            com_idx_q <= 3'h0;
                        end else begin
                            com_idx_q <= com_idx_q + 3'h1;
                        end
                    end
                end
                ST_EVEN: begin
                    if (slot_end) begin
                        if (com_idx_q >= last_com) begin
                            state_q <= ST_ODD;
                            com_idx_q <= 3'h0;
                        end else begin
                            com_idx_q <= com_idx_q + 3'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Waveform levels; idle pins sit at ground so no DC reaches the glass
    for (genvar s = 0; s < NSEG; s++) begin : g_seg_lvl
        always_comb begin
            if (state_q == ST_IDLE) begin
                seg_lvl_d[s] = `LCD_LVL_GND;
            end else begin
                seg_lvl_d[s] = drive_level(1'b0, seg_bits[s], half_bias,
                                           state_q == ST_EVEN);
            end
        end
    end

    for (genvar c = 0; c < NCOM; c++) begin : g_com_lvl
        always_comb begin
            if (state_q == ST_IDLE || c > last_com) begin
                com_lvl_d[c] = `LCD_LVL_GND;
            end else begin
                com_lvl_d[c] = drive_level(1'b1, com_idx_q == c, half_bias,
                                           state_q == ST_EVEN);
            end
            // Shared pins carry the top four segments in 4-common mode
            if (four_com && c >= 4 && state_q != ST_IDLE) begin
                com_lvl_d[c] = seg_lvl_d[NSEG-NCOM+c];
            end
        end
    end

    // One register stage only, so memory writes show the next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NSEG; i++) begin
                seg_lvl_q[i] <= `LCD_LVL_GND;
            end
            for (int i = 0; i < NCOM; i++) begin
                com_lvl_q[i] <= `LCD_LVL_GND;
            end
        end else begin
            seg_lvl_q <= seg_lvl_d;
            com_lvl_q <= com_lvl_d;
        end
    end

    assign segment_outputs = seg_lvl_q;
    assign common_outputs = com_lvl_q;
endmodule

// >>> testbench/lcd_ctrl_properties.sv
// Port checker for lcd_ctrl, bound to every instance.
// Shadows CTRL1 and CTRL2 writes seen on the AHB-Lite port.
`timescale 1ns/1ps
`include "lcd_ctrl_cfg.svh"
module lcd_ctrl_props #(
    parameter int NCOM = 8,
    parameter int NSEG = 44
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire lcd_ctrl_pkg::drive_level_t common_outputs [NCOM],
    input wire lcd_ctrl_pkg::drive_level_t segment_outputs [NSEG],
    input wire logic divider_connect,
    input wire logic drive_cutoff_switch,
    input wire logic frame_irq
);
    import lcd_ctrl_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [11:0] a_q;
    logic w_q;
    logic [31:0] ctl_q;
    logic ien_q;
    logic lvl_nz;
    logic take;
    logic [2:0] mode;
    logic run_fast;
    assign take = hsel && hready && htrans[1];
    assign mode = ctl_q[2:0];
    // Shortest timing only: peripheral clock, no division
    assign run_fast = mode == `LCD_MODE_8COM && ctl_q[5] && ctl_q[15:8] == 0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_q <= 1'b0;
            a_q <= 12'h000;
        end else begin
            w_q <= take && hwrite;
            a_q <= haddr[11:0];
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 32'h0;
            ien_q <= 1'b0;
        end else if (w_q && a_q == `LCD_OFS_CTRL1) begin
            ctl_q <= hwdata;
        end else if (w_q && a_q == `LCD_OFS_CTRL2) begin
            ien_q <= hwdata[`LCD_F_IEN];
        end
    end
    always_comb begin
        lvl_nz = 1'b0;
        for (int i = 0; i < NCOM; i++) lvl_nz |= common_outputs[i] != 0;
        for (int i = 0; i < NSEG; i++) lvl_nz |= segment_outputs[i] != 0;
    end
    cutoff_on_a: assert property (mode != 3'h0 |-> drive_cutoff_switch)
        else $error("cutoff switch off while mode set");
    cutoff_off_a: assert property (mode == 3'h0 |-> !drive_cutoff_switch)
        else $error("cutoff switch on while stopped");
    divider_on_a: assert property ($rose(ctl_q[3]) |-> ##[0:1] divider_connect)
        else $error("divider not connected");
    divider_off_a: assert property ($fell(ctl_q[3]) |-> ##[0:1] !divider_connect)
        else $error("divider not released");
    idle_quiet_a: assert property (
        (mode == 3'h0 || mode > 3'h4) [*4] |-> !lvl_nz)
        else $error("waveform while stopped");
    frame_invert_a: assert property (
        run_fast && $rose(common_outputs[0] == 3'h4)
        |-> ##32 (!run_fast || common_outputs[0] == 3'h0))
        else $error("even frame not inverted");
    slot_step_a: assert property (
        run_fast && $rose(common_outputs[0] == 3'h4)
        |-> (common_outputs[0] == 3'h4) [*4] ##1 common_outputs[1] == 3'h4)
        else $error("common slot length wrong");
    irq_gate_a: assert property (frame_irq |-> ien_q)
        else $error("request while disabled");
    shared_pin_a: assert property (
        (mode != 3'h0 && mode < 3'h4) [*4]
        |-> common_outputs[4] == segment_outputs[40])
        else $error("shared common pin not a segment");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    cover property (run_fast && common_outputs[0] == 3'h4);
    cover property (frame_irq);
    cover property (take && !hwrite);
endmodule

bind lcd_ctrl lcd_ctrl_props #(.NCOM(NCOM), .NSEG(NSEG)) i_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .common_outputs(common_outputs),
    .segment_outputs(segment_outputs), .divider_connect(divider_connect),
    .drive_cutoff_switch(drive_cutoff_switch), .frame_irq(frame_irq)
);

// >>> testbench/lcd_panel_model.sv
// Passive glass: reports whether segment 0 shows at any common.
// Lit means full swing; unused commons at ground may mislead in 4COM.
`timescale 1ns/1ps
module lcd_panel_model #(
    parameter int NCOM = 8,
    parameter int NSEG = 44
) (
    input wire lcd_ctrl_pkg::drive_level_t common_outputs [NCOM],
    input wire lcd_ctrl_pkg::drive_level_t segment_outputs [NSEG],
    output logic seg0_lit
);
    import lcd_ctrl_pkg::*;
    always_comb begin
        seg0_lit = 1'b0;
        for (int i = 0; i < NCOM; i++) begin
            if ((common_outputs[i] == 3'h4 && segment_outputs[0] == 3'h0) ||
                (common_outputs[i] == 3'h0 && segment_outputs[0] == 3'h4)) begin
                seg0_lit = 1'b1;
            end
        end
    end
endmodule

// >>> testbench/tb_segment_lcd_drive_controller.sv
// Self-checking bench for lcd_ctrl over AHB-Lite with a panel model.
// Peripheral clock 250 MHz; sub-clock pulse every third cycle.
`timescale 1ns/1ps
`include "lcd_ctrl_cfg.svh"
module tb_segment_lcd_drive_controller;
    import lcd_ctrl_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sub_clk_tick = 1'b0;
    logic hreadyout, hresp, port_input_control, divider_connect;
    logic drive_cutoff_switch, frame_irq, seg0_lit;
    logic [31:0] hrdata;
    logic [7:0] common_pin_enable;
    logic [43:0] segment_pin_enable;
    logic [4:0] drive_level_pin_enable;
    drive_level_t common_outputs [8];
    drive_level_t segment_outputs [44];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int sub_cnt = 0;
    int n;

    lcd_ctrl i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .sub_clk_tick(sub_clk_tick),
        .common_outputs(common_outputs), .segment_outputs(segment_outputs),
        .common_pin_enable(common_pin_enable),
        .segment_pin_enable(segment_pin_enable),
        .drive_level_pin_enable(drive_level_pin_enable),
        .port_input_control(port_input_control),
        .divider_connect(divider_connect),
        .drive_cutoff_switch(drive_cutoff_switch), .frame_irq(frame_irq)
    );
    lcd_panel_model i_panel (
        .common_outputs(common_outputs), .segment_outputs(segment_outputs),
        .seg0_lit(seg0_lit)
    );

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        sub_cnt <= (sub_cnt == 2) ? 0 : sub_cnt + 1;
        sub_clk_tick <= (sub_cnt == 2);
        cycles <= cycles + 1;
        // Whole run needs about three hundred cycles
        if (cycles == 6000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        total_checks++;
        if (seen !== expd) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic lv(input drive_level_t s, input drive_level_t e);
        check({29'h0, s}, {29'h0, e});
    endtask
    // Holds each phase until hready is seen high at a rising edge
    task automatic bus_xfer(input logic w, input logic [11:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus_xfer(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        bus_xfer(1'b0, a, 32'h0, rd);
        check(rd, e);
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wait_com(input int k, input drive_level_t l);
        @(negedge sys_clk);
        for (int i = 0; i < 400 && common_outputs[k] !== l; i++)
            @(negedge sys_clk);
        lv(common_outputs[k], l);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(`LCD_OFS_CTRL1, 32'h0);
        rdc(`LCD_OFS_CTRL2, 32'h0);
        rdc(`LCD_OFS_STATUS, 32'h0);
        rdc(12'h040, 32'h0);
        wr(12'h044, 32'hFFFF_FFFF);
        rdc(12'h044, 32'h0);
        $display("test reset_and_map done");
        wr(`LCD_OFS_CTRL3, 32'h1F);
        wr(`LCD_OFS_COMEN, 32'hFF);
        wr(`LCD_OFS_SEGEN2, 32'h0000_0FFF);
        wr(`LCD_OFS_SEGEN1, 32'hA5A5_A5A5);
        @(negedge sys_clk);
        check(segment_pin_enable[31:0], 32'hA5A5_A5A5);
        check({27'h0, drive_level_pin_enable}, 32'h1F);
        check({24'h0, common_pin_enable}, 32'hFF);
        check({20'h0, segment_pin_enable[43:32]}, 32'hFFF);
        wr(`LCD_OFS_CTRL3, 32'h0);
        wr(`LCD_OFS_CTRL3, 32'h20);
        @(negedge sys_clk);
        check({31'h0, port_input_control}, 32'h1);
        $display("test pin_enables done");
        wr(`LCD_OFS_CTRL1, 32'h8);
        @(negedge sys_clk);
        check({30'h0, divider_connect, drive_cutoff_switch}, 32'h2);
        for (int m = 1; m < 8; m++) begin
            wr(`LCD_OFS_CTRL1, 32'(m));
            @(negedge sys_clk);
            check({31'h0, drive_cutoff_switch}, 32'h1);
        end
        check({31'h0, divider_connect}, 32'h0);
        repeat (6) @(negedge sys_clk);
        lv(common_outputs[0], 3'h0);
        wr(`LCD_OFS_CTRL1, 32'h0000_AB1C);
        rdc(`LCD_OFS_CTRL1, 32'h0000_AB1C);
        $display("test divider_cutoff done");
        wr(`LCD_OFS_CTRL1, 32'h0);
        wr(`LCD_RAM_BASE, 32'h0000_0201);
        wr(`LCD_OFS_CTRL1, 32'h24);
        wait_com(0, 3'h4);
        lv(segment_outputs[0], 3'h0);
        lv(segment_outputs[1], 3'h2);
        check({31'h0, seg0_lit}, 32'h1);
        repeat (4) @(negedge sys_clk);
        lv(common_outputs[1], 3'h4);
        lv(segment_outputs[1], 3'h0);
        repeat (28) @(negedge sys_clk);
        lv(common_outputs[0], 3'h0);
        lv(segment_outputs[0], 3'h4);
        wr(`LCD_RAM_BASE, 32'h0000_02FF);
        repeat (2) @(negedge sys_clk);
        lv(segment_outputs[0], 3'h4);
        repeat (64) @(negedge sys_clk);
        wr(`LCD_OFS_CTRL1, 32'h0);
        @(negedge sys_clk);
        check({31'h0, frame_irq}, 32'h0);
        rdc(`LCD_OFS_CTRL2, 32'h1);
        wr(`LCD_OFS_CTRL2, 32'h3);
        @(negedge sys_clk);
        check({31'h0, frame_irq}, 32'h1);
        wr(`LCD_OFS_CTRL2, 32'h2);
        @(negedge sys_clk);
        check({31'h0, frame_irq}, 32'h0);
        rdc(`LCD_OFS_CTRL2, 32'h2);
        $display("test eight_common done");
        wr(`LCD_RAM_BASE, 32'h0000_0021);
        wr(`LCD_RAM_BASE + 12'h014, 32'h0000_0002);
        wr(`LCD_OFS_CTRL1, 32'h21);
        wait_com(0, 3'h4);
        lv(segment_outputs[0], 3'h0);
        lv(segment_outputs[1], 3'h4);
        lv(common_outputs[1], 3'h2);
        lv(common_outputs[2], 3'h0);
        lv(common_outputs[4], 3'h4);
        $display("test four_common done");
        wr(`LCD_OFS_CTRL1, 32'h0);
        wr(`LCD_OFS_CTRL1, 32'h0000_0104);
        wait_com(1, 3'h4);
        n = 0;
        while (common_outputs[1] === 3'h4 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(n, 32'd24);
        wr(`LCD_OFS_CTRL1, 32'h0);
        $display("test sub_clock done");
        final_report();
    end
endmodule
